// file: rtl/pll_ctrl_pkg.sv
// shared constants and carrier types for the reference switchover and phase control block
package pll_ctrl_pkg;
  localparam int   TAPS          = 8;
  localparam int   TAP_W         = 3;
  localparam int   CNT_W         = 9;
  localparam int   SYNC_STAGES   = 2;
  localparam int   LOSS_CYCLES   = 2;
  localparam int   SWITCH_HOLD   = 3;
  localparam int   CLK_PERIOD_NS = 100;
  localparam int   SCAN_STEP_NS  = 100;
  localparam int   SCAN_STEP_CYC = (SCAN_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [8:0] HIGH_RST = 9'h001;
  localparam logic [8:0] LOW_RST  = 9'h001;
  localparam logic [8:0] START_RST = 9'h001;
  localparam logic [2:0] TAP_RST  = 3'h0;

  typedef enum logic [1:0] {
    MODE_AUTO     = 2'h0,
    MODE_MANUAL   = 2'h1,
    MODE_OVERRIDE = 2'h2
  } sw_mode_t;

  typedef struct packed {
    logic [CNT_W-1:0] high_cnt;
    logic [CNT_W-1:0] low_cnt;
    logic [CNT_W-1:0] start_cnt;
  } cnt_cfg_t;

  typedef struct packed {
    logic loss_primary;
    logic loss_backup;
    logic active_backup;
  } ref_status_t;
endpackage

// file: rtl/post_scale_counter.sv
// one post-scale output counter: high/low counts, start delay and phase tap
`timescale 1ns/1ps
module post_scale_counter
  import pll_ctrl_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic            run,
  input  wire pll_ctrl_pkg::cnt_cfg_t cfg,
  input  wire logic [TAPS-1:0] vco_taps,
  input  wire logic [TAP_W-1:0] tap_sel,
  output logic                 tap_clk,
  output logic                 out_q
);
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic             phase_q, phase_d;
  logic             started_q, started_d;
  logic [CNT_W-1:0] hold_q, hold_d;
  logic             out_d;

  // any of the eight equally spaced taps may act as reference
  assign tap_clk = vco_taps[tap_sel];

  always_comb begin
    cnt_d     = cnt_q;
    phase_d   = phase_q;
    started_d = started_q;
    hold_d    = hold_q;
    out_d     = 1'b0;
    if (!run) begin
      cnt_d     = {CNT_W{1'b0}};
      phase_d   = 1'b1;
      started_d = 1'b0;
      hold_d    = {CNT_W{1'b0}};
    end else if (!started_q) begin
      // start count C holds off C-1 VCO periods
      if (hold_q + 9'h001 >= cfg.start_cnt) begin
        started_d = 1'b1;
        out_d     = 1'b1;
        cnt_d     = 9'h001;
      end else begin
        hold_d = hold_q + 9'h001;
      end
    end else begin
      // duty step is 100% over division value, since high+low is division
      if (cnt_q >= (phase_q ? cfg.high_cnt : cfg.low_cnt)) begin
        phase_d = !phase_q;
        cnt_d   = 9'h001;
      end else begin
        cnt_d = cnt_q + 9'h001;
      end
      out_d = phase_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q     <= {CNT_W{1'b0}};
      phase_q   <= 1'b1;
      started_q <= 1'b0;
      hold_q    <= {CNT_W{1'b0}};
      out_q     <= 1'b0;
    end else begin
      cnt_q     <= cnt_d;
      phase_q   <= phase_d;
      started_q <= started_d;
      hold_q    <= hold_d;
      out_q     <= out_d;
    end
  end

  first_start_a: assert property (@(posedge clk) disable iff (rst)
    (run && !started_q && hold_q + 9'h001 >= cfg.start_cnt) |=> out_q)
    else $error("counter did not start after hold-off");
endmodule

// file: rtl/pll_ref_switchover.sv
// reference switchover, clock sense, status and phase-step control around the PLL
`timescale 1ns/1ps
// Contract
// - output counter duty comes from separate high and low VCO counts.
// - duty step equals 50% over the counter division value; the counters step 100% over it.
// - each counter may use any of eight equally spaced VCO taps.
// - finest phase step is one VCO period over eight.
// - start count C delays the counter C-1 VCO periods.
// - only tap selection steps at run time, one scan clock each, unlimited.
// - two reference inputs; selector switched automatically or by request.
// - automatic mode moves to other input when selected one stops.
// - request held high three cycles after rising edge swaps reference.
// - in override mode a high request blocks further automatic switchover.
// - three status outputs: two loss flags and active input.
// - loss flag rises when sense logic finds the input stopped; the code holds both flags low in manual mode.
// - active indication always shows the selected reference.
// - backup reference is the second input, used when current is absent.
// - automatic switching back and forth repeats without limit.
// - manual mode selects the first input after reset.
// - gate on old input falling edge, move mux on new input falling edge.
// - loss flagged after input stays low about two reference cycles.
module pll_ref_switchover
  import pll_ctrl_pkg::*;
#(
  parameter int NCNT = 5
) (
  input  wire logic                 CLK,
  input  wire logic                 RST,
  input  wire logic                 PRIMARY_REF_CLOCK,
  input  wire logic                 BACKUP_REF_CLOCK,
  input  wire logic [TAPS-1:0]      VCO_TAPS,
  input  wire pll_ctrl_pkg::sw_mode_t SWITCH_MODE,
  input  wire logic                 SWITCH_REQ,
  input  wire pll_ctrl_pkg::cnt_cfg_t CNT_CFG [NCNT],
  input  wire logic                 PHASE_STEP,
  input  wire logic [2:0]           PHASE_CNT_SEL,
  input  wire logic                 PHASE_UP,
  input  wire logic                 COUNTERS_RUN,
  output logic                      REF_OUT,
  output pll_ctrl_pkg::ref_status_t STATUS,
  output logic                      PHASE_DONE,
  output logic [NCNT-1:0]           COUNTER_OUT,
  output logic [TAP_W-1:0]          FB_TAP
);
  typedef enum logic [2:0] {
    ST_RUN  = 3'b001,
    ST_GATE = 3'b010,
    ST_MOVE = 3'b100
  } sw_state_t;

  // two-flop synchronisers for the pins
  logic       p_s1, b_s1, r_s1;
  logic       p_sync, b_sync, req_sync, req_prev_q;
  logic       p_prev_q, b_prev_q;

  always_ff @(posedge CLK) begin
    if (RST) begin
      p_s1 <= 1'b0;
      b_s1 <= 1'b0;
      r_s1 <= 1'b0;
      p_sync <= 1'b0;
      b_sync <= 1'b0;
      req_sync <= 1'b0;
    end else begin
      p_s1 <= PRIMARY_REF_CLOCK;
      b_s1 <= BACKUP_REF_CLOCK;
      r_s1 <= SWITCH_REQ;
      p_sync <= p_s1;
      b_sync <= b_s1;
      req_sync <= r_s1;
    end
  end

  // clock sense: count sampled cycles with input low
  localparam int LOW_LIMIT = LOSS_CYCLES * 4;
  logic [3:0] p_low_q, p_low_d, b_low_q, b_low_d;
  logic       p_bad, b_bad;
  assign p_bad = (p_low_q >= 4'(LOW_LIMIT));
  assign b_bad = (b_low_q >= 4'(LOW_LIMIT));

  always_comb begin
    p_low_d = p_sync ? 4'h0 : (p_bad ? p_low_q : p_low_q + 4'h1);
    b_low_d = b_sync ? 4'h0 : (b_bad ? b_low_q : b_low_q + 4'h1);
  end

  // switchover state
  sw_state_t  st_q, st_d;
  logic       sel_q, sel_d;      // 0 primary, 1 backup
  logic       gate_q, gate_d;
  logic [1:0] hold_q, hold_d;
  logic       armed_q, armed_d;
  logic       block_q, block_d;
  logic       p_fall, b_fall, old_fall, new_fall, new_bad, cur_bad;
  logic       manual_go, auto_go;

  assign p_fall   = p_prev_q && !p_sync;
  assign b_fall   = b_prev_q && !b_sync;
  assign old_fall = sel_q ? b_fall : p_fall;
  assign new_fall = sel_q ? p_fall : b_fall;
  assign cur_bad  = sel_q ? b_bad : p_bad;
  assign new_bad  = sel_q ? p_bad : b_bad;

  always_comb begin
    hold_d  = hold_q;
    armed_d = armed_q;
    manual_go = 1'b0;
    // rising edge arms, three high cycles fire once
    if (!req_sync) begin
      hold_d  = 2'h0;
      armed_d = 1'b1;
    end else if (armed_q) begin
      if (32'(hold_q) + 1 >= SWITCH_HOLD) begin
        manual_go = 1'b1;
        armed_d   = 1'b0;
      end else begin
        hold_d = hold_q + 2'h1;
      end
    end
    if (req_prev_q == 1'b0 && req_sync == 1'b1 && !armed_q) armed_d = 1'b1;
  end

  always_comb begin
    auto_go = 1'b0;
    block_d = (SWITCH_MODE == MODE_OVERRIDE) && req_sync;
    // only switch to a live clock; both dead means wait
    if (SWITCH_MODE != MODE_MANUAL && cur_bad && !new_bad && !block_q)
      auto_go = 1'b1;
  end

  always_comb begin
    st_d   = st_q;
    sel_d  = sel_q;
    gate_d = gate_q;
    unique case (st_q)
      ST_RUN: begin
        if (((SWITCH_MODE != MODE_AUTO) && manual_go) || auto_go)
          st_d = ST_GATE;
      end
      ST_GATE: begin
        // glitch-free: stop the reference on the old clock's falling edge
        if (old_fall || cur_bad) begin
          gate_d = 1'b1;
          st_d   = ST_MOVE;
        end
      end
      ST_MOVE: begin
        if (new_fall && !new_bad) begin
          sel_d  = !sel_q;
          gate_d = 1'b0;
          st_d   = ST_RUN;
        end
      end
      default: st_d = ST_RUN;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      p_low_q    <= 4'h0;
      b_low_q    <= 4'h0;
      p_prev_q   <= 1'b0;
      b_prev_q   <= 1'b0;
      req_prev_q <= 1'b0;
      st_q       <= ST_RUN;
      sel_q      <= 1'b0;
      gate_q     <= 1'b0;
      hold_q     <= 2'h0;
      armed_q    <= 1'b0;
      block_q    <= 1'b0;
    end else begin
      p_low_q    <= p_low_d;
      b_low_q    <= b_low_d;
      p_prev_q   <= p_sync;
      b_prev_q   <= b_sync;
      req_prev_q <= req_sync;
      st_q       <= st_d;
      sel_q      <= sel_d;
      gate_q     <= gate_d;
      hold_q     <= hold_d;
      armed_q    <= armed_d;
      block_q    <= block_d;
    end
  end

  // status registered for the fabric
  ref_status_t status_d;
  logic        ref_d;
  always_comb begin
    status_d.loss_primary  = (SWITCH_MODE != MODE_MANUAL) && p_bad;
    status_d.loss_backup   = (SWITCH_MODE != MODE_MANUAL) && b_bad;
    status_d.active_backup = sel_q;
    ref_d = !gate_q && (sel_q ? b_sync : p_sync);
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      STATUS  <= '0;
      REF_OUT <= 1'b0;
    end else begin
      STATUS  <= status_d;
      REF_OUT <= ref_d;
    end
  end

  // dynamic phase stepping: only tap selections move at run time
  logic [TAP_W-1:0] tap_q [NCNT+1];
  logic [TAP_W-1:0] tap_d [NCNT+1];
  logic             step_s1, step_sync, step_prev_q, done_d;

  always_ff @(posedge CLK) begin
    if (RST) begin
      step_s1   <= 1'b0;
      step_sync <= 1'b0;
    end else begin
      step_s1   <= PHASE_STEP;
      step_sync <= step_s1;
    end
  end

  always_comb begin
    tap_d  = tap_q;
    done_d = 1'b0;
    if (step_sync && !step_prev_q && 32'(PHASE_CNT_SEL) <= NCNT) begin
      tap_d[PHASE_CNT_SEL] = PHASE_UP ? tap_q[PHASE_CNT_SEL] + 3'h1
                                      : tap_q[PHASE_CNT_SEL] - 3'h1;
      done_d = 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      for (int i = 0; i <= NCNT; i++) tap_q[i] <= TAP_RST;
      step_prev_q <= 1'b0;
      PHASE_DONE  <= 1'b0;
      FB_TAP      <= TAP_RST;
    end else begin
      tap_q       <= tap_d;
      step_prev_q <= step_sync;
      PHASE_DONE  <= done_d;
      FB_TAP      <= tap_d[NCNT];
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCNT; g++) begin : g_cnt
      post_scale_counter u_cnt (
        .clk      (CLK),
        .rst      (RST),
        .run      (COUNTERS_RUN),
        .cfg      (CNT_CFG[g]),
        .vco_taps (VCO_TAPS),
        .tap_sel  (tap_q[g]),
        .tap_clk  (),
        .out_q    (COUNTER_OUT[g])
      );
    end
  endgenerate

  sequence req_held3;
    req_sync [*3];
  endsequence

  active_follows_a: assert property (@(posedge CLK) disable iff (RST)
    STATUS.active_backup == $past(sel_q))
    else $error("active indication disagrees with selection");
  loss_flag_a: assert property (@(posedge CLK) disable iff (RST)
    (SWITCH_MODE == MODE_AUTO && p_bad) |=> STATUS.loss_primary)
    else $error("loss flag missing");
  sense_count_a: assert property (@(posedge CLK) disable iff (RST)
    !p_sync [*8] |=> p_bad)
    else $error("stopped input not sensed");
  auto_switch_a: assert property (@(posedge CLK) disable iff (RST)
    (st_q == ST_RUN && auto_go) |=> st_q == ST_GATE)
    else $error("automatic switch not started");
  manual_swap_a: assert property (@(posedge CLK) disable iff (RST)
    (SWITCH_MODE == MODE_MANUAL && st_q == ST_RUN && !req_sync ##1 req_held3)
      |=> st_q == ST_GATE)
    else $error("manual request ignored");
  override_block_a: assert property (@(posedge CLK) disable iff (RST)
    (block_q && SWITCH_MODE == MODE_OVERRIDE && !manual_go && st_q == ST_RUN)
      |=> st_q == ST_RUN)
    else $error("switch while override held");
  move_on_fall_a: assert property (@(posedge CLK) disable iff (RST)
    (sel_q != $past(sel_q)) |-> $past(new_fall && st_q == ST_MOVE))
    else $error("mux moved off a falling edge");
  manual_start_a: assert property (@(posedge CLK)
    $past(RST) |-> !sel_q)
    else $error("reset did not select first input");
  step_done_a: assert property (@(posedge CLK) disable iff (RST)
    (step_sync && !step_prev_q && PHASE_CNT_SEL == 3'h0)
      |=> PHASE_DONE && tap_q[0] != $past(tap_q[0]))
    else $error("phase step not applied");
endmodule

// file: bench/ref_clock_pair.sv
// two reference clock sources that can each be stopped low on command
`timescale 1ns/1ps
module ref_clock_pair #(
  parameter int HALF_NS = 400
) (
  input  wire logic run_primary,
  input  wire logic run_backup,
  output logic      primary_clk,
  output logic      backup_clk
);
  // equal frequencies keep both loss flags meaningful
  initial begin
    primary_clk = 1'h0;
    forever #(HALF_NS) primary_clk = run_primary ? ~primary_clk : 1'h0;
  end
  // skewed start so the two inputs are never edge aligned
  initial begin
    backup_clk = 1'h0;
    #(HALF_NS / 3);
    forever #(HALF_NS) backup_clk = run_backup ? ~backup_clk : 1'h0;
  end
endmodule

// file: bench/pll_ref_switchover_test.sv
// self-checking bench for reference switchover and phase stepping
`timescale 1ns/1ps
module pll_ref_switchover_test;
  import pll_ctrl_pkg::*;
  logic        clk, rst, p_clk, b_clk, run_p, run_b, sw_req;
  logic        ph_step, ph_up, cnt_run, ref_out, ph_done;
  logic [4:0]  c_prev;
  logic [2:0]  p_hist, b_hist;
  logic [7:0]  vco_taps;
  logic [2:0]  ph_sel, fb_tap;
  logic [4:0]  cnt_out;
  sw_mode_t    mode;
  cnt_cfg_t    cfg [5];
  ref_status_t status;
  int          err_total, checked, seed, act_m, tap_m, dones, dones_m, n_cyc, i;
  int          c_rises [5], c_high [5], c_first [5];

  ref_clock_pair refs (.run_primary(run_p), .run_backup(run_b),
                       .primary_clk(p_clk), .backup_clk(b_clk));

  pll_ref_switchover dut (.CLK(clk), .RST(rst), .PRIMARY_REF_CLOCK(p_clk),
    .BACKUP_REF_CLOCK(b_clk), .VCO_TAPS(vco_taps), .SWITCH_MODE(mode),
    .SWITCH_REQ(sw_req), .CNT_CFG(cfg), .PHASE_STEP(ph_step), .PHASE_CNT_SEL(ph_sel),
    .PHASE_UP(ph_up), .COUNTERS_RUN(cnt_run), .REF_OUT(ref_out), .STATUS(status),
    .PHASE_DONE(ph_done), .COUNTER_OUT(cnt_out), .FB_TAP(fb_tap));

  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    c_prev <= cnt_out;
    p_hist <= {p_hist[1:0], p_clk};
    b_hist <= {b_hist[1:0], b_clk};
    for (int k = 0; k < 5; k++) begin
      if (cnt_out[k] === 1'h1 && c_prev[k] === 1'h0) c_rises[k]++;
      if (cnt_out[k] === 1'h1) c_high[k]++;
    end
    if (ph_done === 1'h1) dones++;
  end

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task print_verdict;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task do_reset;
    rst = 1'h1;
    repeat (2) @(negedge clk);
    rst = 1'h0;
    act_m = 0;
    repeat (3) @(negedge clk);
  endtask

  // request is held whole cycles from one falling edge
  task req_pulse(input int cyc);
    sw_req = 1'h1;
    repeat (cyc) @(negedge clk);
    sw_req = 1'h0;
    @(negedge clk);
  endtask

  task wait_active(input int limit);
    int n;
    n = 0;
    while (status.active_backup !== act_m[0] && n < limit) begin
      @(negedge clk);
      n++;
    end
    check("active_backup", 32'(status.active_backup), 32'(act_m));
  endtask

  // selected pin reaches the reference output through two sync flops and the output flop
  task check_ref;
    int n, bad;
    bad = 0;
    for (n = 0; n < 16; n++) begin
      @(negedge clk);
      if (ref_out !== (act_m[0] ? b_hist[2] : p_hist[2])) bad++;
    end
    check("ref_out follows input", 32'(bad), 32'h0);
  endtask

  initial begin
    seed = 82;
    err_total = 0;
    checked = 0;
    dones = 0;
    dones_m = 0;
    rst = 1'h1;
    run_p = 1'h1;
    run_b = 1'h1;
    sw_req = 1'h0;
    ph_step = 1'h0;
    ph_up = 1'h0;
    ph_sel = 3'h5;
    cnt_run = 1'h1;
    mode = MODE_MANUAL;
    vco_taps = 8'($random(seed));
    // high count i+1 and low count 2 give dividers of 3 to 7
    for (i = 0; i < 5; i++) cfg[i] = '{9'(i + 1), 9'h002, 9'h001};
    repeat (10) @(negedge clk);
    rst = 1'h0;
    act_m = 0;
    repeat (3) @(negedge clk);
    check("status after reset", 32'(status), 32'h0);
    check("fb_tap after reset", 32'(fb_tap), 32'h0);
    // a one-cycle request is too short to count
    req_pulse(1);
    repeat (40) @(negedge clk);
    wait_active(1);
    for (i = 0; i < 2; i++) begin
      req_pulse(4);
      act_m ^= 1;
      wait_active(300);
      check_ref();
      check("manual loss bits", 32'(status[2:1]), 32'h0);
    end
    // 420 cycles hold whole periods of every divider from 3 to 7
    for (i = 0; i < 5; i++) begin
      c_rises[i] = 0;
      c_high[i] = 0;
    end
    repeat (420) @(negedge clk);
    for (i = 0; i < 5; i++) begin
      check("counter rises", 32'(c_rises[i]), 32'(420 / (i + 3)));
      check("counter high", 32'(c_high[i]), 32'(420 * (i + 1) / (i + 3)));
    end
    // start count C holds a counter back C-1 cycles
    cnt_run = 1'h0;
    for (i = 0; i < 5; i++) cfg[i].start_cnt = 9'(i + 1);
    @(negedge clk);
    cnt_run = 1'h1;
    for (i = 0; i < 5; i++) c_first[i] = 0;
    for (n_cyc = 1; n_cyc <= 8; n_cyc++) begin
      @(negedge clk);
      for (i = 0; i < 5; i++) begin
        if (c_first[i] == 0 && cnt_out[i] === 1'h1) c_first[i] = n_cyc;
      end
    end
    for (i = 0; i < 5; i++) begin
      check("start delay", 32'(c_first[i] - c_first[0]), 32'(i));
    end
    do_reset();
    mode = MODE_AUTO;
    req_pulse(4);
    repeat (60) @(negedge clk);
    wait_active(1);
    for (i = 0; i < 4; i++) begin
      if (act_m == 0) run_p = 1'h0;
      else run_b = 1'h0;
      act_m ^= 1;
      wait_active(300);
      check_ref();
      repeat (5) @(negedge clk);
      check("loss bits", 32'(status[2:1]), act_m == 1 ? 32'h2 : 32'h1);
      run_p = 1'h1;
      run_b = 1'h1;
      repeat (60) @(negedge clk);
      check("loss cleared", 32'(status[2:1]), 32'h0);
    end
    do_reset();
    mode = MODE_OVERRIDE;
    sw_req = 1'h1;
    act_m = 1;
    wait_active(300);
    run_b = 1'h0;
    repeat (300) @(negedge clk);
    wait_active(1);
    run_b = 1'h1;
    repeat (20) @(negedge clk);
    // backup is live again, so dropping the request must not move the selection
    sw_req = 1'h0;
    repeat (60) @(negedge clk);
    wait_active(1);
    tap_m = 0;
    dones = 0;
    for (i = 0; i < 24; i++) begin
      ph_up = 1'($random(seed));
      ph_sel = (i % 3 == 0) ? 3'($random(seed)) : 3'h5;
      // one pass always steps output counter 0
      if (i == 3) ph_sel = 3'h0;
      vco_taps = 8'($random(seed));
      ph_step = 1'h1;
      repeat (4) @(negedge clk);
      if (ph_sel == 3'h5) tap_m = (tap_m + (ph_up ? 1 : 7)) % 8;
      if (ph_sel <= 3'h5) dones_m++;
      check("fb_tap", 32'(fb_tap), 32'(tap_m));
      ph_step = 1'h0;
      repeat (3) @(negedge clk);
    end
    check("phase done pulses", 32'(dones), 32'(dones_m));
    print_verdict();
  end

  initial begin
    #(100 * 20000);
    err_total++;
    print_verdict();
  end
endmodule
